// ### pkg/pfd_pkg.sv
// Field layout and special operand constants for the parcel field decoder
package pfd_pkg;
  // ==========================================================
  // Packing
  localparam int PARCEL_W   = 16;
  localparam int PARCELS    = 4;
  localparam int WORD_W     = PARCEL_W * PARCELS;
  localparam int INSTR_W    = 2 * PARCEL_W;
  localparam int PSEL_W     = 2;
  // ==========================================================
  // Field positions within the 32-bit instruction window
  localparam int G_HI       = 31;
  localparam int G_LO       = 28;
  localparam int H_HI       = 27;
  localparam int H_LO       = 25;
  localparam int I_HI       = 24;
  localparam int I_LO       = 22;
  localparam int J_HI       = 21;
  localparam int J_LO       = 19;
  localparam int K_HI       = 18;
  localparam int K_LO       = 16;
  localparam int GH_W       = 7;
  localparam int G_W        = 4;
  localparam int DES_W      = 3;
  localparam int JK_W       = 6;
  localparam int JKM_W      = 22;
  localparam int IJKM_W     = 24;
  localparam int WADDR_W    = 22;
  // ==========================================================
  // Register widths and special operands
  localparam int A_W        = 24;
  localparam int S_W        = 64;
  localparam int S_SIGN_POS = 63;
  localparam logic [DES_W-1:0] REG_ZERO   = 3'h0;
  localparam logic [A_W-1:0]   A_ZERO_VAL = 24'h000000;
  localparam logic [A_W-1:0]   A_ONE_VAL  = 24'h000001;
  localparam logic [S_W-1:0]   S_ZERO_VAL = 64'h0000000000000000;
  localparam logic [S_W-1:0]   S_SIGN_VAL = 64'h8000000000000000;
  // ==========================================================
  // Operand slots with substitution
  localparam int A_SLOTS    = 3;
  localparam int S_SLOTS    = 2;
endpackage

// ### src/pfd_decoder.sv
// Parcel format field decoder: field extraction and special operands
// Notes on behaviour
// - Accept 16-bit and 32-bit instructions; two parcels may span into next word.
// - Combined format treats j and k as one 6-bit constant or designator.
// - Combined format: g and h are opcode, i is destination.
// - 22-bit immediate: 7-bit opcode, 3-bit result designator, jkm constant.
// - Scalar memory: 4-bit opcode, h index, i source/result, 22-bit displacement.
// - Branch: 7-bit opcode then 24-bit parcel address; i high bit zero.
// - 24-bit immediate recognised by i high bit set; g opcode, h result.
// - Register zero in j or k field yields a generated constant.
// - Special constant skips reservation check and never alters register zero.
// - Register zero in i field delivers real stored contents.
// - Scalar zero as second operand gives only bit 63 set.
// - Address zero as second operand gives the value one.
`timescale 1ns/1ps
module pfd_decoder
  import pfd_pkg::*;
#(
  parameter int AW = 24,
  parameter int SW = 64
)
(
  input  wire logic                         clk_sys,
  input  wire logic                         nrst,
  // Fetch side
  input  wire logic                         in_valid,
  output logic                              in_ready,
  input  wire logic [pfd_pkg::WORD_W-1:0]   word_cur,
  input  wire logic [pfd_pkg::WORD_W-1:0]   word_next,
  input  wire logic [pfd_pkg::PSEL_W-1:0]   parcel_sel,
  input  wire logic                         two_parcel,
  // Register read ports, combinational answer
  output logic      [pfd_pkg::DES_W-1:0]    a_rd_h,
  output logic      [pfd_pkg::DES_W-1:0]    a_rd_i,
  output logic      [pfd_pkg::DES_W-1:0]    a_rd_j,
  output logic      [pfd_pkg::DES_W-1:0]    a_rd_k,
  output logic      [pfd_pkg::DES_W-1:0]    s_rd_i,
  output logic      [pfd_pkg::DES_W-1:0]    s_rd_j,
  output logic      [pfd_pkg::DES_W-1:0]    s_rd_k,
  input  wire logic [AW-1:0]                a_h_data,
  input  wire logic [AW-1:0]                a_i_data,
  input  wire logic [AW-1:0]                a_j_data,
  input  wire logic [AW-1:0]                a_k_data,
  input  wire logic [SW-1:0]                s_i_data,
  input  wire logic [SW-1:0]                s_j_data,
  input  wire logic [SW-1:0]                s_k_data,
  // Issue side
  output logic                              out_valid,
  input  wire logic                         out_ready,
  output logic                              out_two_parcel,
  output logic      [pfd_pkg::GH_W-1:0]     out_opcode_gh,
  output logic      [pfd_pkg::G_W-1:0]      out_opcode_g,
  output logic      [pfd_pkg::DES_W-1:0]    out_fld_h,
  output logic      [pfd_pkg::DES_W-1:0]    out_fld_i,
  output logic      [pfd_pkg::DES_W-1:0]    out_fld_j,
  output logic      [pfd_pkg::DES_W-1:0]    out_fld_k,
  output logic      [pfd_pkg::JK_W-1:0]     out_fld_jk,
  output logic      [pfd_pkg::JKM_W-1:0]    out_imm22,
  output logic      [pfd_pkg::IJKM_W-1:0]   out_imm24,
  output logic                              out_is_imm24,
  output logic                              out_is_branch,
  output logic      [pfd_pkg::WADDR_W-1:0]  out_br_word,
  output logic      [pfd_pkg::PSEL_W-1:0]   out_br_parcel,
  output logic      [AW-1:0]                out_a_h,
  output logic      [AW-1:0]                out_a_i,
  output logic      [AW-1:0]                out_a_j,
  output logic      [AW-1:0]                out_a_k,
  output logic      [SW-1:0]                out_s_i,
  output logic      [SW-1:0]                out_s_j,
  output logic      [SW-1:0]                out_s_k,
  output logic      [pfd_pkg::A_SLOTS-1:0]  out_a_res_chk,
  output logic      [pfd_pkg::S_SLOTS-1:0]  out_s_res_chk
);
  import pfd_pkg::*;

  // ==========================================================
  // Elaboration checks
  generate
    if (AW != A_W) begin : g_bad_aw
      $error("pfd_decoder: AW must match the address register width");
    end
    if (SW != S_W) begin : g_bad_sw
      $error("pfd_decoder: SW must match the scalar register width");
    end
  endgenerate

  // ==========================================================
  // Parcel alignment
  logic [INSTR_W-1:0] win;

  pfd_parcel_align u_align (
    .word_cur   (word_cur),
    .word_next  (word_next),
    .parcel_sel (parcel_sel),
    .two_parcel (two_parcel),
    .instr_win  (win)
  );

  // ==========================================================
  // Field extraction, all format views in parallel
  wire [G_W-1:0]    g_w    = win[G_HI:G_LO];
  wire [DES_W-1:0]  h_w    = win[H_HI:H_LO];
  wire [DES_W-1:0]  i_w    = win[I_HI:I_LO];
  wire [DES_W-1:0]  j_w    = win[J_HI:J_LO];
  wire [DES_W-1:0]  k_w    = win[K_HI:K_LO];
  wire [GH_W-1:0]   gh_w   = win[G_HI:H_LO];
  wire [JK_W-1:0]   jk_w   = win[J_HI:K_LO];
  wire [JKM_W-1:0]  jkm_w  = win[JKM_W-1:0];
  wire [IJKM_W-1:0] ijkm_w = win[IJKM_W-1:0];
  wire              imsb_w = win[I_HI];

  // Long forms only exist with a second parcel
  wire              imm24_w  = two_parcel && imsb_w;
  wire              branch_w = two_parcel && !imsb_w;
  wire [JKM_W-1:0]  imm22_w  = two_parcel ? jkm_w : 22'h000000;
  wire [IJKM_W-1:0] ijkm_q_w = two_parcel ? ijkm_w : 24'h000000;

  // Branch target split: word address over parcel select
  wire [WADDR_W-1:0] br_word_w = ijkm_q_w[IJKM_W-1:PSEL_W];
  wire [PSEL_W-1:0]  br_parc_w = ijkm_q_w[PSEL_W-1:0];

  // ==========================================================
  // Register read addresses
  assign a_rd_h = h_w;
  assign a_rd_i = i_w;
  assign a_rd_j = j_w;
  assign a_rd_k = k_w;
  assign s_rd_i = i_w;
  assign s_rd_j = j_w;
  assign s_rd_k = k_w;

  // ==========================================================
  // Special operand substitution for h, j, k address and j, k scalar
  logic [AW-1:0] a_desig_data [A_SLOTS];
  logic [AW-1:0] a_special    [A_SLOTS];
  logic [AW-1:0] a_opnd       [A_SLOTS];
  logic [DES_W-1:0] a_desig   [A_SLOTS];
  logic [SW-1:0] s_desig_data [S_SLOTS];
  logic [SW-1:0] s_special    [S_SLOTS];
  logic [SW-1:0] s_opnd       [S_SLOTS];
  logic [DES_W-1:0] s_desig   [S_SLOTS];
  logic [A_SLOTS-1:0] a_chk_w;
  logic [S_SLOTS-1:0] s_chk_w;

  // Slot 0 index h, slot 1 first operand j, slot 2 second operand k
  assign a_desig[0]      = h_w;
  assign a_desig[1]      = j_w;
  assign a_desig[2]      = k_w;
  assign a_desig_data[0] = a_h_data;
  assign a_desig_data[1] = a_j_data;
  assign a_desig_data[2] = a_k_data;
  assign a_special[0]    = A_ZERO_VAL;
  assign a_special[1]    = A_ZERO_VAL;
  assign a_special[2]    = A_ONE_VAL;

  // Slot 0 first operand j, slot 1 second operand k
  assign s_desig[0]      = j_w;
  assign s_desig[1]      = k_w;
  assign s_desig_data[0] = s_j_data;
  assign s_desig_data[1] = s_k_data;
  assign s_special[0]    = S_ZERO_VAL;
  assign s_special[1]    = S_SIGN_VAL;

  genvar ga;
  generate
    for (ga = 0; ga < A_SLOTS; ga++) begin : g_a_sub
      pfd_zero_subst #(.W(AW)) u_sub (
        .desig        (a_desig[ga]),
        .reg_data     (a_desig_data[ga]),
        .special      (a_special[ga]),
        .operand      (a_opnd[ga]),
        .need_res_chk (a_chk_w[ga])
      );
    end
    for (ga = 0; ga < S_SLOTS; ga++) begin : g_s_sub
      pfd_zero_subst #(.W(SW)) u_sub (
        .desig        (s_desig[ga]),
        .reg_data     (s_desig_data[ga]),
        .special      (s_special[ga]),
        .operand      (s_opnd[ga]),
        .need_res_chk (s_chk_w[ga])
      );
    end
  endgenerate

  // ==========================================================
  // Handshake: one-deep output stage, stalls when issue stalls
  wire take_w = in_valid && in_ready;
  assign in_ready = out_ready || !out_valid;

  // ==========================================================
  // Output stage registers
  logic                valid_r;
  logic                two_r;
  logic [GH_W-1:0]     gh_r;
  logic [G_W-1:0]      g_r;
  logic [DES_W-1:0]    h_r;
  logic [DES_W-1:0]    i_r;
  logic [DES_W-1:0]    j_r;
  logic [DES_W-1:0]    k_r;
  logic [JK_W-1:0]     jk_r;
  logic [JKM_W-1:0]    imm22_r;
  logic [IJKM_W-1:0]   imm24_r;
  logic                is_imm24_r;
  logic                is_br_r;
  logic [WADDR_W-1:0]  br_word_r;
  logic [PSEL_W-1:0]   br_parc_r;
  logic [AW-1:0]       a_h_r;
  logic [AW-1:0]       a_i_r;
  logic [AW-1:0]       a_j_r;
  logic [AW-1:0]       a_k_r;
  logic [SW-1:0]       s_i_r;
  logic [SW-1:0]       s_j_r;
  logic [SW-1:0]       s_k_r;
  logic [A_SLOTS-1:0]  a_chk_r;
  logic [S_SLOTS-1:0]  s_chk_r;

  wire valid_nxt = take_w || (valid_r && !out_ready);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
    end
  end

  // Decoded fields
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      two_r      <= 1'b0;
      gh_r       <= '0;
      g_r        <= '0;
      h_r        <= '0;
      i_r        <= '0;
      j_r        <= '0;
      k_r        <= '0;
      jk_r       <= '0;
    end else if (take_w) begin
      two_r      <= two_parcel;
      gh_r       <= gh_w;
      g_r        <= g_w;
      h_r        <= h_w;
      i_r        <= i_w;
      j_r        <= j_w;
      k_r        <= k_w;
      jk_r       <= jk_w;
    end
  end

  // Immediate and branch fields
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      imm22_r    <= '0;
      imm24_r    <= '0;
      is_imm24_r <= 1'b0;
      is_br_r    <= 1'b0;
      br_word_r  <= '0;
      br_parc_r  <= '0;
    end else if (take_w) begin
      imm22_r    <= imm22_w;
      imm24_r    <= ijkm_q_w;
      is_imm24_r <= imm24_w;
      is_br_r    <= branch_w;
      br_word_r  <= br_word_w;
      br_parc_r  <= br_parc_w;
    end
  end

  // Operands; i slot always carries the true register contents
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      a_h_r   <= '0;
      a_i_r   <= '0;
      a_j_r   <= '0;
      a_k_r   <= '0;
      s_i_r   <= '0;
      s_j_r   <= '0;
      s_k_r   <= '0;
      a_chk_r <= '0;
      s_chk_r <= '0;
    end else if (take_w) begin
      a_h_r   <= a_opnd[0];
      a_i_r   <= a_i_data;
      a_j_r   <= a_opnd[1];
      a_k_r   <= a_opnd[2];
      s_i_r   <= s_i_data;
      s_j_r   <= s_opnd[0];
      s_k_r   <= s_opnd[1];
      a_chk_r <= a_chk_w;
      s_chk_r <= s_chk_w;
    end
  end

  // ==========================================================
  // Outputs
  assign out_valid      = valid_r;
  assign out_two_parcel = two_r;
  assign out_opcode_gh  = gh_r;
  assign out_opcode_g   = g_r;
  assign out_fld_h      = h_r;
  assign out_fld_i      = i_r;
  assign out_fld_j      = j_r;
  assign out_fld_k      = k_r;
  assign out_fld_jk     = jk_r;
  assign out_imm22      = imm22_r;
  assign out_imm24      = imm24_r;
  assign out_is_imm24   = is_imm24_r;
  assign out_is_branch  = is_br_r;
  assign out_br_word    = br_word_r;
  assign out_br_parcel  = br_parc_r;
  assign out_a_h        = a_h_r;
  assign out_a_i        = a_i_r;
  assign out_a_j        = a_j_r;
  assign out_a_k        = a_k_r;
  assign out_s_i        = s_i_r;
  assign out_s_j        = s_j_r;
  assign out_s_k        = s_k_r;
  // No write port here: register zero is only ever read
  assign out_a_res_chk  = a_chk_r;
  assign out_s_res_chk  = s_chk_r;
endmodule // pfd_decoder

// ### src/pfd_parcel_align.sv
// Picks the one- or two-parcel instruction window out of two fetched words
`timescale 1ns/1ps
module pfd_parcel_align
  import pfd_pkg::*;
(
  input  wire logic [pfd_pkg::WORD_W-1:0]  word_cur,
  input  wire logic [pfd_pkg::WORD_W-1:0]  word_next,
  input  wire logic [pfd_pkg::PSEL_W-1:0]  parcel_sel,
  input  wire logic                        two_parcel,
  output logic      [pfd_pkg::INSTR_W-1:0] instr_win
);
  // ==========================================================
  // Parcel slicing, parcel 0 leftmost
  logic [PARCEL_W-1:0] parc [PARCELS];
  genvar gi;
  generate
    for (gi = 0; gi < PARCELS; gi++) begin : g_parc
      assign parc[gi] = word_cur[WORD_W-1-gi*PARCEL_W -: PARCEL_W];
    end
  endgenerate

  // ==========================================================
  // Second parcel wraps into parcel 0 of the next word
  wire                 wrap_w   = (parcel_sel == 2'h3);
  wire [PSEL_W-1:0]    sel2_w   = PSEL_W'(parcel_sel + 2'h1);
  wire [PARCEL_W-1:0]  first_w  = parc[parcel_sel];
  wire [PARCEL_W-1:0]  second_w = wrap_w ? word_next[WORD_W-1 -: PARCEL_W]
                                         : parc[sel2_w];
  // One-parcel forms leave the low half zero so stale bits never leak
  assign instr_win = {first_w, two_parcel ? second_w : 16'h0000};
endmodule // pfd_parcel_align

// ### src/pfd_zero_subst.sv
// Swaps a register-zero operand for its generated constant
`timescale 1ns/1ps
module pfd_zero_subst
  import pfd_pkg::*;
#(
  parameter int W = 24
)
(
  input  wire logic [pfd_pkg::DES_W-1:0] desig,
  input  wire logic [W-1:0]              reg_data,
  input  wire logic [W-1:0]              special,
  output logic      [W-1:0]              operand,
  output logic                           need_res_chk
);
  // ==========================================================
  // Substitution
  wire is_zero_w = (desig == REG_ZERO);
  assign operand      = is_zero_w ? special : reg_data;
  // Constants bypass the reservation scoreboard entirely
  assign need_res_chk = !is_zero_w;
endmodule // pfd_zero_subst

// ### test/pfd_decoder_sva.sv
// Checker for the parcel field decoder ports
`timescale 1ns/1ps
module pfd_decoder_sva (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        in_valid,
  input wire logic        in_ready,
  input wire logic        out_ready,
  input wire logic        out_valid,
  input wire logic        two_parcel,
  input wire logic [1:0]  parcel_sel,
  input wire logic [2:0]  a_rd_h,
  input wire logic [2:0]  a_rd_j,
  input wire logic [2:0]  a_rd_k,
  input wire logic [23:0] a_i_data,
  input wire logic [63:0] s_i_data,
  input wire logic        out_two_parcel,
  input wire logic [2:0]  out_fld_h,
  input wire logic [2:0]  out_fld_i,
  input wire logic [2:0]  out_fld_j,
  input wire logic [2:0]  out_fld_k,
  input wire logic [5:0]  out_fld_jk,
  input wire logic [23:0] out_imm24,
  input wire logic        out_is_imm24,
  input wire logic        out_is_branch,
  input wire logic [21:0] out_br_word,
  input wire logic [1:0]  out_br_parcel,
  input wire logic [23:0] out_a_h,
  input wire logic [23:0] out_a_i,
  input wire logic [23:0] out_a_j,
  input wire logic [23:0] out_a_k,
  input wire logic [63:0] out_s_i,
  input wire logic [63:0] out_s_j,
  input wire logic [63:0] out_s_k,
  input wire logic [2:0]  out_a_res_chk
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire take = in_valid && in_ready;
  // ==========================================
  // Handshake
  a_ready_follow: assert property (in_ready == (out_ready || !out_valid))
    else $error("ready does not follow the issue side");
  a_take_valid: assert property (take |=> out_valid)
    else $error("no result one cycle after a take");
  a_hold_stall: assert property (out_valid && !out_ready |=> out_valid && $stable(out_imm24)
    && $stable(out_a_k)) else $error("result changed while stalled");
  // ==========================================
  // Fields
  a_fields_match: assert property (take |=> out_fld_h == $past(a_rd_h)
    && out_fld_k == $past(a_rd_k)) else $error("fields differ from read designators");
  a_jk_joined: assert property (out_valid |-> out_fld_jk == {out_fld_j, out_fld_k})
    else $error("combined field wrong");
  a_kind_split: assert property (out_valid |-> out_is_imm24 == (out_two_parcel && out_fld_i[2])
    && out_is_branch == (out_two_parcel && !out_fld_i[2])) else $error("format flags wrong");
  a_br_split: assert property (out_valid && out_is_branch |-> {out_br_word, out_br_parcel} == out_imm24)
    else $error("branch address split wrong");
  // ==========================================
  // Special operands
  a_i_real: assert property (take |=> out_a_i == $past(a_i_data) && out_s_i == $past(s_i_data))
    else $error("result field operand not real contents");
  a_k_special: assert property (take && a_rd_k == 3'h0 |=> out_a_k == 24'h000001
    && out_s_k == 64'h8000000000000000 && !out_a_res_chk[2]) else $error("second operand constant wrong");
  a_j_zero: assert property (take && a_rd_j == 3'h0 |=> out_a_j == 24'h000000 && out_s_j == 64'h0)
    else $error("first operand zero wrong");
  a_h_zero: assert property (take && a_rd_h == 3'h0 |=> out_a_h == 24'h000000 && !out_a_res_chk[0])
    else $error("index operand zero wrong");
  c_span: cover property (take && two_parcel && parcel_sel == 2'h3);
  c_stall: cover property (out_valid && !out_ready);
  c_kzero: cover property (take && a_rd_k == 3'h0);
endmodule // pfd_decoder_sva

// ### test/pfd_reg_model.sv
// Register file model answering the decoder's read ports
`timescale 1ns/1ps
module pfd_reg_model (
  input  wire logic [31:0] key,
  input  wire logic [2:0]  a_rd_h,
  input  wire logic [2:0]  a_rd_i,
  input  wire logic [2:0]  a_rd_j,
  input  wire logic [2:0]  a_rd_k,
  input  wire logic [2:0]  s_rd_i,
  input  wire logic [2:0]  s_rd_j,
  input  wire logic [2:0]  s_rd_k,
  output logic      [23:0] a_h_data,
  output logic      [23:0] a_i_data,
  output logic      [23:0] a_j_data,
  output logic      [23:0] a_k_data,
  output logic      [63:0] s_i_data,
  output logic      [63:0] s_j_data,
  output logic      [63:0] s_k_data
);
  // Register zero never reads 0, 1 or the sign value, so a missed swap shows
  function automatic logic [23:0] fa(input logic [31:0] k, input logic [2:0] n);
    return {k[23:4], 1'b1, n};
  endfunction
  function automatic logic [63:0] fs(input logic [31:0] k, input logic [2:0] n);
    return {k, k[31:5], 2'h3, n};
  endfunction
  assign a_h_data = fa(key, a_rd_h);
  assign a_i_data = fa(key, a_rd_i);
  assign a_j_data = fa(key, a_rd_j);
  assign a_k_data = fa(key, a_rd_k);
  assign s_i_data = fs(key, s_rd_i);
  assign s_j_data = fs(key, s_rd_j);
  assign s_k_data = fs(key, s_rd_k);
endmodule // pfd_reg_model

// ### test/tb_top.sv
// Self-checking testbench for the parcel field decoder
`timescale 1ns/1ps
module tb_top;
  import pfd_pkg::*;
  typedef struct packed {logic [101:0] f; logic [292:0] o;} pfd_exp_t;
  logic clk_sys = 1'b0, nrst = 1'b0, in_valid = 1'b0, two_parcel = 1'b0, out_ready = 1'b0, stall = 1'b0;
  logic [63:0] word_cur = 64'h0, word_next = 64'h0;
  logic [31:0] key = 32'h0, seed = 32'h09f63980, rs;
  logic [1:0] parcel_sel = 2'h0, out_br_parcel, out_s_res_chk;
  logic in_ready, out_valid, out_two_parcel, out_is_imm24, out_is_branch;
  logic [2:0] a_rd_h, a_rd_i, a_rd_j, a_rd_k, s_rd_i, s_rd_j, s_rd_k, out_a_res_chk;
  logic [2:0] out_fld_h, out_fld_i, out_fld_j, out_fld_k;
  logic [23:0] a_h_data, a_i_data, a_j_data, a_k_data, out_a_h, out_a_i, out_a_j, out_a_k, out_imm24;
  logic [63:0] s_i_data, s_j_data, s_k_data, out_s_i, out_s_j, out_s_k;
  logic [6:0] out_opcode_gh;
  logic [3:0] out_opcode_g;
  logic [5:0] out_fld_jk;
  logic [21:0] out_imm22, out_br_word;
  int fails = 0, checked = 0;
  pfd_exp_t q[$];
  pfd_exp_t x;
  wire [101:0] got_f = {out_two_parcel, out_opcode_gh, out_opcode_g, out_fld_h, out_fld_i, out_fld_j, out_fld_k,
                       out_fld_jk, out_imm22, out_imm24, out_is_imm24, out_is_branch, out_br_word, out_br_parcel};
  wire [292:0] got_o = {out_a_h, out_a_i, out_a_j, out_a_k, out_s_i, out_s_j, out_s_k, out_a_res_chk, out_s_res_chk};
  pfd_decoder pfd_decoder_i (.*);
  pfd_reg_model pfd_reg_model_i (.*);
  always #12.5 clk_sys = ~clk_sys;
  // ==========================================
  // Stimulus helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [23:0] fa(input logic [31:0] k, input logic [2:0] n);
    return {k[23:4], 1'b1, n};
  endfunction
  function automatic logic [63:0] fs(input logic [31:0] k, input logic [2:0] n);
    return {k, k[31:5], 2'h3, n};
  endfunction
  function automatic pfd_exp_t expect_of(input logic [31:0] w, input logic t, input logic [31:0] k);
    logic [2:0] h, i, j, c;
    pfd_exp_t r;
    h = w[27:25];
    i = w[24:22];
    j = w[21:19];
    c = w[18:16];
    // Branch target: word address above, parcel select in the low two bits
    r.f = {t, w[31:25], w[31:28], h, i, j, c, w[21:16], t ? w[21:0] : 22'h0, t ? w[23:0] : 24'h0,
           t & w[24], t & !w[24], t ? w[23:2] : 22'h0, t ? w[1:0] : 2'h0};
    r.o = {h == 3'h0 ? A_ZERO_VAL : fa(k, h), fa(k, i), j == 3'h0 ? A_ZERO_VAL : fa(k, j),
           c == 3'h0 ? A_ONE_VAL : fa(k, c), fs(k, i), j == 3'h0 ? S_ZERO_VAL : fs(k, j),
           c == 3'h0 ? S_SIGN_VAL : fs(k, c), c != 3'h0, j != 3'h0, h != 3'h0, c != 3'h0, j != 3'h0};
    return r;
  endfunction
  // Parcels are placed anywhere in the word pair; the expectation only knows p0 and p1
  task automatic issue(input logic [15:0] p0, input logic [15:0] p1, input logic t, input logic [1:0] sel);
    logic [63:0] wc, wn;
    logic [31:0] kk;
    int n;
    wc = {rnd(), rnd()};
    wn = {rnd(), rnd()};
    kk = rnd();
    wc[63-16*int'(sel) -: 16] = p0;
    if (t && sel == 2'h3) wn[63:48] = p1;
    else if (t) wc[47-16*int'(sel) -: 16] = p1;
    in_valid <= 1'b1;
    word_cur <= wc;
    word_next <= wn;
    parcel_sel <= sel;
    two_parcel <= t;
    key <= kk;
    #5;
    n = 0;
    while (in_ready !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      #5;
      n++;
    end
    if (n == 50) fails++;
    q.push_back(expect_of(t ? {p0, p1} : {p0, 16'h0}, t, kk));
    @(negedge clk_sys);
  endtask
  task automatic run_set(input int cnt, input bit rand_mode);
    logic [31:0] v, p, p1;
    stall = rand_mode;
    for (int i = 0; i < cnt; i++) begin
      v = rand_mode ? rnd() : i;
      p = rnd();
      p1 = rnd();
      if (v[3]) p &= 32'hf1c7;
      if (v[4]) p &= 32'hfe38;
      issue(p[15:0], p1[15:0], v[2], v[1:0]);
    end
    in_valid <= 1'b0;
    stall = 1'b0;
    for (int n = 0; q.size() > 0 && n < 100; n++) @(negedge clk_sys);
    // A result that never came out is a mismatch too
    if (q.size() > 0) fails++;
    $display("test %s done, checked %0d", rand_mode ? "stall" : "directed", checked);
  endtask
  // ==========================================
  // Checking
  task automatic cmp_f(input logic [101:0] e, input logic [101:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected fields at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic cmp_o(input logic [292:0] e, input logic [292:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected operands at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(negedge clk_sys) begin
    rs = rnd();
    out_ready <= !stall || rs[0];
  end
  always @(posedge clk_sys) begin
    if (nrst && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (q.size() == 0) begin
        fails++;
        $display("unexpected result at %0t: exp %h got %h", $time, 102'h0, got_f);
      end else begin
        x = q.pop_front();
        cmp_f(x.f, got_f);
        cmp_o(x.o, got_o);
      end
    end
  end
  // Whole run needs under 1500 cycles; the margin covers long stall runs
  initial begin
    repeat (6000) @(posedge clk_sys);
    fails++;
    print_verdict();
  end
  initial begin
    repeat (2) @(negedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    run_set(32, 1'b0);
    run_set(300, 1'b1);
    print_verdict();
  end
endmodule // tb_top
bind pfd_decoder pfd_decoder_sva pfd_decoder_sva_i (.*);
